//--- sram_port_pkg.sv
/*
 * Shared widths and encodings for the synchronous late-write word port.
 * Assumes a single clock domain; the controller runs on the same clock.
 */
package sram_port_pkg;
    localparam int ADDR_W  = 17;
    localparam int LANES   = 4;
    localparam int LANE_W  = 9;
    localparam int WORD_W  = LANES * LANE_W;
    localparam int DEPTH   = 1 << ADDR_W;
    localparam logic [LANES-1:0] NO_LANES  = 4'h0;
    localparam logic [LANES-1:0] ALL_LANES = 4'hF;
    localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0;
endpackage

//--- sram_word_array.sv
/*
 * Word storage with per-lane write strobes and an unregistered read port.
 * Assumes the caller registers the read result and orders writes itself.
 */
`timescale 1ns/100ps
module sram_word_array (
    // Clock
    input  wire logic                                clock,
    // Write side
    input  wire logic                                wr_en,
    input  wire logic [sram_port_pkg::ADDR_W-1:0]    wr_addr,
    input  wire logic [sram_port_pkg::LANES-1:0]     wr_lanes,
    input  wire logic [sram_port_pkg::WORD_W-1:0]    wr_data,
    // Read side
    input  wire logic [sram_port_pkg::ADDR_W-1:0]    rd_addr,
    output logic      [sram_port_pkg::WORD_W-1:0]    rd_data
);
    // No reset: contents are undefined at power-up, as in a real array
    logic [sram_port_pkg::WORD_W-1:0] words_reg [sram_port_pkg::DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            for (int i = 0; i < sram_port_pkg::LANES; i++) begin
                if (wr_lanes[i]) begin
                    words_reg[wr_addr][i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] <=
                        wr_data[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
                end
            end
        end
    end

    assign rd_data = words_reg[rd_addr];
endmodule

//--- sync_sram_host_port.sv
/*
 * Synchronous late-write static RAM port: controls, address and lane
 * enables are taken on the rising edge, write data one edge later, read
 * data driven from a register one edge later for one cycle.
 * Assumes the differential clock pair is already resolved into clock,
 * and that the controller leaves an idle cycle between a read and a write.
 * The word array itself has no reset; only the port state clears.
 * A read right after a write to the same word returns the new data: the
 * array takes the write at the edge that captures the read.
 */
`timescale 1ns/100ps
module sync_sram_host_port (
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                clock_n,
    input  wire logic                                rst_n,
    // Command inputs
    input  wire logic [sram_port_pkg::ADDR_W-1:0]    word_address_in,
    input  wire logic                                chip_select_n,
    input  wire logic                                write_select_n,
    input  wire logic [sram_port_pkg::LANES-1:0]     lane_write_enable_n,
    input  wire logic                                output_enable_n,
    // Data lanes
    input  wire logic [sram_port_pkg::WORD_W-1:0]    data_lanes_in,
    output logic      [sram_port_pkg::WORD_W-1:0]    data_lanes_out,
    output logic                                     data_lanes_oe
);
    typedef enum logic [1:0] {
        ACC_IDLE  = 2'h0,
        ACC_READ  = 2'h1,
        ACC_WRITE = 2'h2
    } access_t;

    typedef struct packed {
        // Command captured at the last edge, acted on at the next
        access_t                             access;
        logic [sram_port_pkg::ADDR_W-1:0]    addr;
        logic [sram_port_pkg::LANES-1:0]     lanes;
        // Read result and its lane drive, both straight to the pins
        logic [sram_port_pkg::WORD_W-1:0]    rdata;
        logic                                drive;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // One decode for the next-state logic and for the checks, so they agree
    function automatic access_t decode_access(
        input logic sel_n,
        input logic wr_n
    );
        access_t kind;
        kind = ACC_READ;
        if (sel_n) begin
            kind = ACC_IDLE;
        end else if (!wr_n) begin
            kind = ACC_WRITE;
        end
        return kind;
    endfunction

    // Lane enables arrive active low; the array wants a high strobe per lane
    function automatic logic [sram_port_pkg::LANES-1:0] lane_mask(
        input logic [sram_port_pkg::LANES-1:0] en_n
    );
        return ~en_n;
    endfunction

    logic                                wr_en;
    logic [sram_port_pkg::WORD_W-1:0]    array_rdata;

    // Late write: the array is written at the edge after the command
    assign wr_en = (state_reg.access == ACC_WRITE);

    // Array read is combinational; the port registers it into rdata
    sram_word_array sram_word_array_inst (
        .clock    (clock),
        .wr_en    (wr_en),
        .wr_addr  (state_reg.addr),
        .wr_lanes (state_reg.lanes),
        .wr_data  (data_lanes_in),
        .rd_addr  (state_reg.addr),
        .rd_data  (array_rdata)
    );

    // A read drives the lanes in the cycle where a following write would
    // need them for its data, hence the idle cycle the controller must leave
    always_comb begin
        state_next = state_reg;
        state_next.addr = word_address_in;
        state_next.lanes = sram_port_pkg::NO_LANES;
        state_next.drive = 1'b0;
        state_next.access = decode_access(chip_select_n, write_select_n);
        // Lane enables not looked at on a read or a deselected cycle
        if (state_next.access == ACC_WRITE) begin
            state_next.lanes = lane_mask(lane_write_enable_n);
        end else begin
            state_next.lanes = sram_port_pkg::NO_LANES;
        end
        case (state_reg.access)
            ACC_READ: begin
                state_next.rdata = array_rdata;
                state_next.drive = 1'b1;
            end
            ACC_WRITE: begin
                state_next.drive = 1'b0;
            end
            ACC_IDLE: begin
                state_next.drive = 1'b0;
            end
            default: begin
                state_next.access = ACC_IDLE;
            end
        endcase
    end

    // Only the true clock edge is used; clock_n is its mirror
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.access <= ACC_IDLE;
            state_reg.addr   <= sram_port_pkg::ADDR_ZERO;
            state_reg.lanes  <= sram_port_pkg::NO_LANES;
            state_reg.rdata  <= sram_port_pkg::WORD_ZERO;
            state_reg.drive  <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops, no decode after the register
    assign data_lanes_out = state_reg.rdata;
    assign data_lanes_oe  = state_reg.drive;

    // Checks; commands decoded exactly as the next-state logic sees them
    sequence read_cmd_s;
        decode_access(chip_select_n, write_select_n) == ACC_READ;
    endsequence

    sequence write_cmd_s;
        decode_access(chip_select_n, write_select_n) == ACC_WRITE;
    endsequence

    sequence deselect_s;
        decode_access(chip_select_n, write_select_n) == ACC_IDLE;
    endsequence

    sequence full_write_s;
        !chip_select_n && !write_select_n && (lane_write_enable_n == sram_port_pkg::NO_LANES);
    endsequence

    // Sampled values are from before the edge: clock_n is high ahead of a rise
    clock_mirror_a: assert property (@(posedge clock) disable iff (!rst_n)
        clock_n == 1'b1)
        else $error("clock_n is not the complement of clock");

    clock_low_a: assert property (@(negedge clock) disable iff (!rst_n)
        clock_n == 1'b0)
        else $error("clock_n is not low while clock is high");

    addr_capture_a: assert property (@(posedge clock) disable iff (!rst_n)
        read_cmd_s |=> (state_reg.addr == $past(word_address_in)))
        else $error("read address not captured");

    lane_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
        write_cmd_s |=> wr_en && (state_reg.lanes == ~$past(lane_write_enable_n)))
        else $error("write lane mask wrong");

    read_no_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        read_cmd_s |=> !wr_en ##1 data_lanes_oe)
        else $error("read cycle wrote or did not drive");

    deselect_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
        chip_select_n |=> !wr_en ##1 !data_lanes_oe)
        else $error("deselected cycle started an access");

    write_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        write_cmd_s |=> ##1 !data_lanes_oe)
        else $error("write cycle drove the data lanes");

    oe_held_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        !output_enable_n)
        else $error("output enable not held low");

    late_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        (full_write_s ##1 (read_cmd_s and (word_address_in == $past(word_address_in))))
        |=> ##1 (data_lanes_out == $past(data_lanes_in, 2)))
        else $error("late write data not read back");

    write_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
        write_cmd_s |=> (state_reg.addr == $past(word_address_in)))
        else $error("write address not captured");

    lanes_only_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg.lanes != sram_port_pkg::NO_LANES) |-> wr_en)
        else $error("lane mask present outside a write");

    read_lanes_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        read_cmd_s |=> (state_reg.lanes == sram_port_pkg::NO_LANES))
        else $error("read cycle carried a lane mask");

    deselect_lanes_a: assert property (@(posedge clock) disable iff (!rst_n)
        deselect_s |=> (state_reg.lanes == sram_port_pkg::NO_LANES))
        else $error("deselected cycle carried a lane mask");

    write_needs_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_en |-> (!$past(chip_select_n) && !$past(write_select_n)))
        else $error("array written without a write command");

    oe_after_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        data_lanes_oe |-> (!$past(chip_select_n, 2) && $past(write_select_n, 2)))
        else $error("data lanes driven without a read command");

    // Read data holds until the next read completes
    out_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg.access != ACC_READ) |=> $stable(data_lanes_out))
        else $error("read data changed without a read");
endmodule

//--- ctrl_model.sv
/*
 * Controller side of the word port: clock complement and output enable.
 * Assumes the bench drives commands and data itself on the falling edge.
 */
`timescale 1ns/100ps
module ctrl_model (
    // Clock
    input  wire logic clock,
    // Pins held by the controller
    output logic      clock_n,
    output logic      output_enable_n
);
    assign clock_n         = ~clock;
    // Output enable has no function in the device, so it never moves
    assign output_enable_n = 1'b0;
endmodule

//--- sync_sram_host_port_bench.sv
/*
 * Self-checking bench for the word port: writes, lane writes, reads, deselect.
 * Assumes one clock, 20 ns period, and the controller model beside it.
 */
`timescale 1ns/100ps
module sync_sram_host_port_bench;
    logic                                clock = 1'b0;
    logic                                clock_n;
    logic                                rst_n = 1'b0;
    logic [sram_port_pkg::ADDR_W-1:0]    addr = 17'h00000;
    logic                                cs_n = 1'b1;
    logic                                ws_n = 1'b1;
    logic [sram_port_pkg::LANES-1:0]     be_n = 4'hF;
    logic                                oe_n;
    logic [sram_port_pkg::WORD_W-1:0]    din = 36'h000000000;
    logic [sram_port_pkg::WORD_W-1:0]    dout;
    logic                                doe;
    int                                  n_errors = 0;
    int                                  tests_run = 0;
    always #10 clock = ~clock;
    ctrl_model ctrl_model_inst (.clock(clock), .clock_n(clock_n), .output_enable_n(oe_n));
    sync_sram_host_port sync_sram_host_port_inst (
        .clock(clock), .clock_n(clock_n), .rst_n(rst_n), .word_address_in(addr), .chip_select_n(cs_n),
        .write_select_n(ws_n), .lane_write_enable_n(be_n), .output_enable_n(oe_n),
        .data_lanes_in(din), .data_lanes_out(dout), .data_lanes_oe(doe));
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Issue at a falling edge, data one edge later; returns in the read-data cycle
    task automatic cmd(input logic c, input logic w, input logic [3:0] b, input logic [16:0] a,
                       input logic [35:0] d);
        @(negedge clock);
        cs_n = c; ws_n = w; be_n = b; addr = a;
        @(negedge clock);
        cs_n = 1'b1; ws_n = 1'b1; be_n = ~b; addr = ~a; din = d;
        @(negedge clock);
        din = ~d;
    endtask
    task automatic rd(input logic [16:0] a, input logic [3:0] b, input logic [35:0] exp);
        cmd(1'b0, 1'b1, b, a, 36'h5A5A5A5A5);
        check("read oe", {35'h0, doe}, 36'h1);
        check("read data", dout, exp);
        @(negedge clock);
        check("oe drop", {35'h0, doe}, 36'h0);
    endtask
    task automatic sc_full;
        cmd(1'b0, 1'b0, 4'h0, 17'h0A5C3, 36'h9C3A5F0E1);
        rd(17'h0A5C3, 4'hF, 36'h9C3A5F0E1);
    endtask
    task automatic sc_lanes;
        cmd(1'b0, 1'b0, 4'h0, 17'h00042, 36'hFFFFFFFFF);
        cmd(1'b0, 1'b0, 4'hD, 17'h00042, 36'h000000000);
        rd(17'h00042, 4'hF, 36'hFFFFC01FF);
        cmd(1'b0, 1'b0, 4'h6, 17'h00042, 36'h000000000);
        rd(17'h00042, 4'h0, 36'h007FC0000);
        rd(17'h00042, 4'hF, 36'h007FC0000);
    endtask
    task automatic sc_deselect;
        cmd(1'b1, 1'b0, 4'h0, 17'h00042, 36'h123123123);
        check("deselect oe", {35'h0, doe}, 36'h0);
        cmd(1'b1, 1'b1, 4'hF, 17'h00042, 36'h000000000);
        check("deselect read oe", {35'h0, doe}, 36'h0);
        rd(17'h00042, 4'hF, 36'h007FC0000);
    endtask
    task automatic sc_back_to_back;
        @(negedge clock);
        cs_n = 1'b0; ws_n = 1'b0; be_n = 4'h0; addr = 17'h1FFFF;
        @(negedge clock);
        addr = 17'h00000; din = 36'h123456789;
        @(negedge clock);
        cs_n = 1'b1; ws_n = 1'b1; be_n = 4'hF; din = 36'hABCDEF012;
        @(negedge clock);
        din = 36'h543210FED;
        rd(17'h1FFFF, 4'hF, 36'h123456789);
        rd(17'h00000, 4'hF, 36'hABCDEF012);
    endtask
    // Write then read of the same word on the next edge, data riding the read cycle
    task automatic sc_write_read;
        @(negedge clock);
        cs_n = 1'b0; ws_n = 1'b0; be_n = 4'h0; addr = 17'h0F0F0;
        @(negedge clock);
        ws_n = 1'b1; be_n = 4'h5; din = 36'h3C3C3C3C3;
        @(negedge clock);
        cs_n = 1'b1; din = 36'h000000000;
        @(negedge clock);
        check("forward oe", {35'h0, doe}, 36'h1);
        check("forward data", dout, 36'h3C3C3C3C3);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock);
        check("reset oe", {35'h0, doe}, 36'h0);
        rst_n = 1'b1;
        sc_full();
        sc_lanes();
        sc_deselect();
        sc_back_to_back();
        sc_write_read();
        end_sim();
    end
endmodule
